// [hdl/prxo_consts.svh]
`ifndef PRXO_CONSTS_SVH
`define PRXO_CONSTS_SVH

// strap levels when pins float: bits 4:1 pulled down, bit 0 pulled up
`define PRXO_ADDR_DFLT 5'h01
// cycles of strap sampling after reset release
`define PRXO_SETTLE_MAX 2'h3
// two-entry buffer
`define PRXO_BUF_DEPTH 2'h2
`define PRXO_BUF_EMPTY 2'h0
// dibit positions inside a nibble
`define PRXO_DIBIT_LO 1:0
`define PRXO_DIBIT_HI 3:2
`define PRXO_PAD 2'h0
`define PRXO_NIB_ZERO 4'h0

`endif

// [hdl/prxo_pkg.sv]
package prxo_pkg;

	typedef enum logic [1:0] {
		PRXO_MII = 2'h0,
		PRXO_RMII = 2'h1,
		PRXO_RGMII = 2'h2
	} prxo_mode_e;

	typedef enum logic [1:0] {
		PRXO_IDLE = 2'h0,
		PRXO_LOW = 2'h1,
		PRXO_HIGH = 2'h3
	} prxo_lk_e;

	typedef struct packed {
		logic err;
		logic [3:0] nib;
	} prxo_word_s;

	typedef struct packed {
		prxo_word_s [1:0] fifo;
		logic wr;
		logic rd;
		logic [1:0] cnt;
		prxo_word_s xfer;
		logic req;
		logic ack1;
		logic ack2;
		logic [4:0] st1;
		logic [4:0] st2;
		logic [4:0] st3;
		logic [1:0] settle;
		logic [4:0] addr;
		logic done;
	} prxo_sys_s;

	typedef struct packed {
		logic rst1;
		logic rst2;
		logic req1;
		logic req2;
		logic ack;
		logic drv1;
		logic drv2;
		logic crx1;
		logic crx2;
		logic ctx1;
		logic ctx2;
		logic crx3;
		logic ctx3;
		logic crx;
		logic ctx;
		prxo_mode_e mode1;
		prxo_mode_e mode2;
		prxo_word_s nxt;
		logic nxt_v;
		prxo_word_s cur;
		prxo_lk_e st;
		logic [3:0] rxd;
		logic dv;
		logic er;
		logic crs;
	} prxo_lnk_s;

endpackage

// [hdl/prxo_rx_out.sv]
// Function
// RULE_01: receive data outputs change only on the rising edge of the receive clock.
// RULE_02: receive data is meaningful only while data valid is high and the MAC ignores it otherwise.
// RULE_03: in MII and RGMII modes a whole nibble is sent on all four data lines each clock.
// RULE_04: in RMII mode a nibble goes out as two dibits on the two low data lines, low dibit first.
// RULE_05: the four data lines are straps for address bits four to one, defaulting to zero.
// RULE_06: the collision pin is the strap for address bit zero, defaulting to one.
// RULE_07: in MII mode carrier sense is high while receive or transmit medium is busy.
// RULE_08: in RMII mode the carrier output merges carrier with receive data valid.
// RULE_09: in RGMII mode the carrier output carries nothing and is held low.
// RULE_10: in RGMII mode the control line shows valid on the rising edge and error on the falling edge.
// RULE_11: in MII and RMII modes receive error goes high with the rising edge for an error symbol.
// RULE_12: straps are sampled at reset release and latched before the shared pins are driven.
`timescale 1ns/1ps
`include "prxo_consts.svh"

module prxo_rx_out
	import prxo_pkg::*;
(
	// clocks and reset
	input wire logic mclk,
	input wire logic reset,
	input wire logic rx_clk,
	// decoded receive stream
	input wire logic in_valid,
	input wire prxo_word_s in_word,
	output logic in_ready,
	// line status and mode
	input wire logic rx_active,
	input wire logic tx_active,
	input wire prxo_mode_e mode,
	// mac side pins
	output logic [3:0] rxd_o,
	output logic rxd_oe_n,
	input wire logic [3:0] rxd_i,
	input wire logic col_i,
	output logic rx_ctl,
	output logic rx_er,
	output logic crs,
	// latched straps
	output logic [4:0] strap_device_address,
	output logic strap_valid
);

	prxo_sys_s s;
	prxo_sys_s next_s;
	prxo_lnk_s l;
	prxo_lnk_s next_l;
	logic ctl_fall;
	logic push;
	logic pop;

	// system side: buffer, handshake source, strap capture
	always_comb begin
		next_s = s;
		push = in_valid && in_ready;
		pop = (s.cnt != `PRXO_BUF_EMPTY) && (s.req == s.ack2) && s.done;
		next_s.ack1 = l.ack;
		next_s.ack2 = s.ack1;
		if (pop) begin
			next_s.xfer = s.fifo[s.rd];
			next_s.req = ~s.req;
			next_s.rd = ~s.rd;
		end
		if (push) begin
			next_s.fifo[s.wr] = in_word;
			next_s.wr = ~s.wr;
		end
		next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
		next_s.st1 = {rxd_i, col_i};
		next_s.st2 = s.st1;
		next_s.st3 = s.st2;
		if (!s.done) begin
			if (s.settle != `PRXO_SETTLE_MAX) begin
				next_s.settle = s.settle + 2'h1;
			end else if (s.st2 == s.st3) begin
				next_s.addr = s.st3; // [RULE_05] [RULE_06] [RULE_12]
				next_s.done = 1'b1;
			end
		end
		if (reset) begin
			next_s = '0;
			next_s.st1 = `PRXO_ADDR_DFLT;
			next_s.st2 = `PRXO_ADDR_DFLT;
			next_s.st3 = `PRXO_ADDR_DFLT;
			next_s.addr = `PRXO_ADDR_DFLT;
		end
	end

	always_ff @(posedge mclk) begin
		s <= next_s;
	end

	assign in_ready = (s.cnt != `PRXO_BUF_DEPTH);
	assign strap_device_address = s.addr;
	assign strap_valid = s.done;

	// link side on the receive clock
	always_comb begin
		next_l = l;
		next_l.rst1 = reset;
		next_l.rst2 = l.rst1;
		next_l.req1 = s.req;
		next_l.req2 = l.req1;
		next_l.drv1 = s.done;
		next_l.drv2 = l.drv1;
		next_l.crx1 = rx_active;
		next_l.crx2 = l.crx1;
		next_l.ctx1 = tx_active;
		next_l.ctx2 = l.ctx1;
		next_l.crx3 = l.crx2;
		next_l.ctx3 = l.ctx2;
		if (l.crx2 == l.crx3) begin
			next_l.crx = l.crx3;
		end
		if (l.ctx2 == l.ctx3) begin
			next_l.ctx = l.ctx3;
		end
		next_l.mode1 = mode;
		next_l.mode2 = l.mode1;
		if (!l.nxt_v && (l.req2 != l.ack)) begin
			next_l.nxt = s.xfer;
			next_l.nxt_v = 1'b1;
			next_l.ack = ~l.ack;
		end
		unique case (l.st)
			PRXO_IDLE, PRXO_LOW: begin
				if (l.nxt_v && l.drv2) begin
					next_l.cur = l.nxt;
					next_l.nxt_v = 1'b0;
					next_l.dv = 1'b1; // [RULE_01] [RULE_02]
					next_l.er = l.nxt.err; // [RULE_10] [RULE_11]
					if (l.mode2 == PRXO_RMII) begin
						next_l.rxd = {`PRXO_PAD, l.nxt.nib[`PRXO_DIBIT_LO]}; // [RULE_04]
						next_l.st = PRXO_HIGH;
					end else begin
						next_l.rxd = l.nxt.nib; // [RULE_03]
						next_l.st = PRXO_LOW;
					end
				end else begin
					next_l.dv = 1'b0;
					next_l.er = 1'b0;
					next_l.rxd = `PRXO_NIB_ZERO;
					next_l.st = PRXO_IDLE;
				end
			end
			PRXO_HIGH: begin
				next_l.rxd = {`PRXO_PAD, l.cur.nib[`PRXO_DIBIT_HI]}; // [RULE_04]
				next_l.dv = 1'b1;
				next_l.er = l.cur.err; // [RULE_11]
				next_l.st = PRXO_LOW;
			end
			default: begin
				next_l.st = PRXO_IDLE;
			end
		endcase
		unique case (l.mode2)
			PRXO_MII: next_l.crs = l.crx || l.ctx; // [RULE_07]
			PRXO_RMII: next_l.crs = l.crx || next_l.dv; // [RULE_08]
			default: next_l.crs = 1'b0; // [RULE_09]
		endcase
		if (l.rst2) begin
			next_l.ack = 1'b0;
			next_l.nxt_v = 1'b0;
			next_l.st = PRXO_IDLE;
			next_l.rxd = `PRXO_NIB_ZERO;
			next_l.dv = 1'b0;
			next_l.er = 1'b0;
			next_l.crs = 1'b0;
			next_l.crx = 1'b0;
			next_l.ctx = 1'b0;
		end
	end

	always_ff @(posedge rx_clk) begin
		l <= next_l;
	end

	// rgmii error half on the falling edge
	always_ff @(negedge rx_clk) begin
		if (l.rst2) begin
			ctl_fall <= 1'b0;
		end else begin
			ctl_fall <= l.er; // [RULE_10]
		end
	end

	assign rxd_o = l.rxd;
	assign rxd_oe_n = ~l.drv2; // [RULE_12]
	assign rx_ctl = (l.mode2 == PRXO_RGMII) ? (rx_clk ? l.dv : ctl_fall) : l.dv; // [RULE_10]
	assign rx_er = (l.mode2 == PRXO_RGMII) ? 1'b0 : l.er;
	assign crs = l.crs;

	// checks
	dv_has_data_a: assert property ( // [RULE_01]
		@(posedge rx_clk) disable iff (l.rst2)
		$rose(l.dv) |-> $past(l.nxt_v) && $past(l.drv2)
	) else $error("data valid rose without a word");

	nibble_out_a: assert property ( // [RULE_03]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.st != PRXO_HIGH && l.nxt_v && l.drv2 && l.mode2 != PRXO_RMII)
		|=> (rxd_o == $past(l.nxt.nib)) && l.dv
	) else $error("nibble not sent whole");

	dibit_pair_a: assert property ( // [RULE_04]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.st != PRXO_HIGH && l.nxt_v && l.drv2 && l.mode2 == PRXO_RMII)
		|=> (rxd_o == {`PRXO_PAD, $past(l.nxt.nib[`PRXO_DIBIT_LO])})
		##1 (rxd_o == {`PRXO_PAD, $past(l.nxt.nib[`PRXO_DIBIT_HI], 2)}) && l.dv
	) else $error("dibits out of order");

	strap_high_a: assert property ( // [RULE_05]
		@(posedge mclk) disable iff (reset)
		$rose(s.done) |-> (s.addr[4:1] == $past(s.st3[4:1])) && ($past(s.st2) == $past(s.st3))
	) else $error("address bits four to one not latched");

	strap_low_a: assert property ( // [RULE_06]
		@(posedge mclk) disable iff (reset)
		$rose(s.done) |-> s.addr[0] == $past(s.st3[0])
	) else $error("address bit zero not latched");

	mii_carrier_a: assert property ( // [RULE_07]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.mode2 == PRXO_MII && $stable(l.mode2)) |=> crs == $past(l.crx || l.ctx)
	) else $error("carrier does not follow media");

	rmii_crsdv_a: assert property ( // [RULE_08]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.mode2 == PRXO_RMII && $stable(l.mode2) && l.dv) |-> crs
	) else $error("crs_dv low while data valid");

	rgmii_quiet_a: assert property ( // [RULE_09]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.mode2 == PRXO_RGMII) [*2] |-> !crs && !rx_er
	) else $error("carrier active in rgmii");

	rgmii_ctl_a: assert property ( // [RULE_10]
		@(negedge rx_clk) disable iff (l.rst2)
		(l.mode2 == PRXO_RGMII) |=> ctl_fall == $past(l.er)
	) else $error("falling half lost error");

	rx_error_a: assert property ( // [RULE_11]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.st != PRXO_HIGH && l.nxt_v && l.drv2 && l.mode2 != PRXO_RGMII && $stable(l.mode2))
		|=> rx_er == $past(l.nxt.err)
	) else $error("receive error not aligned to data");

	pins_held_a: assert property ( // [RULE_12]
		@(posedge rx_clk) disable iff (l.rst2)
		!l.drv2 |-> rxd_oe_n && (rxd_o == `PRXO_NIB_ZERO) && !l.dv
	) else $error("pins driven before strap latch");

	strap_first_a: assert property ( // [RULE_12]
		@(posedge mclk) disable iff (reset)
		!s.done |-> !pop && (s.req == $past(s.req))
	) else $error("data moved before straps latched");

	word_kept_a: assert property ( // [RULE_02]
		@(posedge mclk) disable iff (reset)
		push |=> s.fifo[$past(s.wr)] == $past(in_word)
	) else $error("buffer lost a word");

	buf_bound_a: assert property ( // [RULE_02]
		@(posedge mclk) disable iff (reset)
		s.cnt <= `PRXO_BUF_DEPTH
	) else $error("buffer count out of range");

	xfer_hold_a: assert property ( // [RULE_02]
		@(posedge mclk) disable iff (reset)
		(s.req != s.ack2) |=> $stable(s.xfer)
	) else $error("crossing word changed in flight");

	ack_pairs_a: assert property ( // [RULE_02]
		@(posedge rx_clk) disable iff (l.rst2)
		$changed(l.ack) |-> $past(l.req2 != l.ack) && l.nxt_v
	) else $error("acknowledge without a request");

	rmii_pad_a: assert property ( // [RULE_04]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.mode2 == PRXO_RMII && $stable(l.mode2)) |-> rxd_o[3:2] == `PRXO_PAD
	) else $error("upper data lines active in rmii");

	err_dibit_a: assert property ( // [RULE_11]
		@(posedge rx_clk) disable iff (l.rst2)
		(l.st == PRXO_HIGH && l.mode2 == PRXO_RMII && $stable(l.mode2))
		|=> (rx_er == $past(l.cur.err)) && l.dv
	) else $error("error not held over second dibit");

	idle_quiet_a: assert property ( // [RULE_02]
		@(posedge rx_clk) disable iff (l.rst2)
		!l.dv |-> !l.er
	) else $error("error raised outside valid data");

	rgmii_rise_a: assert property ( // [RULE_10]
		@(negedge rx_clk) disable iff (l.rst2)
		(l.mode2 == PRXO_RGMII) |-> rx_ctl == l.dv
	) else $error("rising half does not carry data valid");

	strap_order_a: assert property ( // [RULE_12]
		@(posedge rx_clk) disable iff (l.rst2)
		$fell(rxd_oe_n) |-> $past(strap_valid, 2)
	) else $error("pins driven before straps latched");

endmodule

// [tb/prxo_mac_model.sv]
`timescale 1ns/1ps

module prxo_mac_model
	import prxo_pkg::*;
(
	// link pins
	input wire logic rx_clk,
	input wire prxo_mode_e mode,
	input wire logic [3:0] rxd_o,
	input wire logic rx_ctl,
	input wire logic rx_er
);
	prxo_word_s got[$];
	prxo_word_s w;
	logic half;
	logic [1:0] lo;

	// samples a quarter period after the rising edge, after its update
	initial begin
		half = 1'b0;
		lo = 2'h0;
		forever begin
			@(posedge rx_clk);
			#16;
			if (rx_ctl === 1'b1) begin
				w.nib = rxd_o;
				w.err = rx_er;
				if (mode == PRXO_RGMII) begin
					@(negedge rx_clk);
					#16;
					w.err = rx_ctl;
				end
				if (mode != PRXO_RMII) begin
					got.push_back(w);
				end else if (!half) begin
					lo = rxd_o[1:0];
					half = 1'b1;
				end else begin
					w.nib = {rxd_o[1:0], lo};
					got.push_back(w);
					half = 1'b0;
				end
			end
		end
	end
endmodule

// [tb/prxo_rx_out_tb_top.sv]
`timescale 1ns/1ps

module prxo_rx_out_tb_top
	import prxo_pkg::*;
;
	logic mclk, reset, rx_clk, in_valid, in_ready, rx_active, tx_active;
	logic rxd_oe_n, col_i, rx_ctl, rx_er, crs, strap_valid, full_seen;
	logic [3:0] rxd_o, rxd_i;
	logic [4:0] strap_device_address, strap;
	prxo_word_s in_word, w;
	prxo_mode_e mode;
	prxo_word_s exp[$];
	int n_mismatch, checks, seed, m, i, k, c;

	assign rxd_i = rxd_oe_n ? strap[4:1] : rxd_o;
	assign col_i = strap[0];

	prxo_rx_out prxo_rx_out_i (.mclk, .reset, .rx_clk, .in_valid, .in_word, .in_ready, .rx_active, .tx_active,
		.mode, .rxd_o, .rxd_oe_n, .rxd_i, .col_i, .rx_ctl, .rx_er, .crs, .strap_device_address, .strap_valid);
	prxo_mac_model prxo_mac_model_i (.rx_clk, .mode, .rxd_o, .rx_ctl, .rx_er);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		rx_clk = 1'b0;
		#7;
		forever #32 rx_clk = ~rx_clk;
	end

	task complete_run();
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input logic [4:0] seen, input logic [4:0] want);
		checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask

	task bound(input logic ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			complete_run();
		end
	endtask

	function automatic logic carrier(input prxo_mode_e md, input logic rx, input logic tx);
		return (md == PRXO_RGMII) ? 1'b0 : (md == PRXO_RMII) ? rx : (rx | tx);
	endfunction

	initial begin
		seed = 29383;
		n_mismatch = 0;
		checks = 0;
		reset = 1'b1;
		in_valid = 1'b0;
		in_word = '0;
		rx_active = 1'b0;
		tx_active = 1'b0;
		mode = PRXO_MII;
		strap = 5'h01;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		for (m = 0; m < 3; m++) begin
			@(posedge mclk);
			reset <= 1'b1;
			mode <= prxo_mode_e'(m[1:0]);
			strap <= (m == 0) ? 5'h01 : 5'($random(seed));
			repeat (48) @(posedge mclk);
			chk(rxd_oe_n, 1'b1);
			chk(strap_valid, 1'b0);
			reset <= 1'b0;
			for (k = 0; k < 60 && strap_valid !== 1'b1; k++) @(posedge mclk);
			bound(strap_valid);
			chk(strap_device_address, strap);
			full_seen = 1'b0;
			for (i = 0; i < 12; i++) begin
				w = prxo_word_s'($random(seed));
				if (i == 0) w = 5'h1F;
				exp.push_back(w);
				in_valid <= 1'b1;
				in_word <= w;
				for (k = 0; k < 400; k++) begin
					@(posedge mclk);
					if (in_ready === 1'b1) break;
					full_seen = 1'b1;
				end
				bound(in_ready);
			end
			in_valid <= 1'b0;
			chk(full_seen, 1'b1);
			for (k = 0; k < 4000 && prxo_mac_model_i.got.size() < 12; k++) @(posedge mclk);
			bound(prxo_mac_model_i.got.size() == 12);
			for (i = 0; i < 12; i++) chk(prxo_mac_model_i.got.pop_front(), exp.pop_front());
			for (c = 1; c < 5; c++) begin
				rx_active <= c[0];
				tx_active <= c[1];
				repeat (60) @(posedge mclk);
				chk(crs, carrier(mode, c[0], c[1]));
			end
		end
		complete_run();
	end
endmodule
